// ==== tb/scp_link_asserts.sv ====
// concurrent checks on the serial configuration link
`timescale 1ns/1ps
module scp_link_asserts (
    input logic CLK_SYS,
    input logic RST,
    input logic sclk,
    input logic cs_n,
    input logic sdio_host_o,
    input logic sdio_host_oe_n,
    input logic sdio_dev_o,
    input logic sdio_dev_oe_n,
    input logic sdo,
    input logic sdo_oe_n,
    input logic rst_pin,
    input logic sdio
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    logic       sclk_q;
    logic [5:0] rise_cnt;
    logic [5:0] next_rise_cnt;
    // rising serial clock edges seen in the current frame
    always_comb begin
        next_rise_cnt = rise_cnt;
        if (cs_n)
            next_rise_cnt = 6'h00;
        else if (sclk && !sclk_q)
            next_rise_cnt = rise_cnt + 6'h01;
    end
    always_ff @(posedge CLK_SYS) begin
        sclk_q <= RST ? 1'b0 : sclk;
        rise_cnt <= RST ? 6'h00 : next_rise_cnt;
    end
    chk_idle_release: assert property (
        cs_n [*5] |-> sdio_dev_oe_n && sdo_oe_n)
        else $error("device drives link while deselected");
    chk_no_contention: assert property (
        !(!sdio_host_oe_n && !sdio_dev_oe_n))
        else $error("both ends drive the data line");
    chk_idle_sclk: assert property (
        cs_n |-> !sclk)
        else $error("serial clock high outside a frame");
    chk_cs_setup: assert property (
        $fell(cs_n) |-> !sclk [*2])
        else $error("serial clock rises too soon after select");
    chk_data_setup: assert property (
        sclk && !sclk_q && !sdio_host_oe_n |-> $stable(sdio_host_o))
        else $error("host data moved at the rising edge");
    chk_data_hold: assert property (
        sclk && !sclk_q && !sdio_host_oe_n
        |=> sdio_host_oe_n || $stable(sdio_host_o))
        else $error("host data moved right after the rising edge");
    chk_sclk_half: assert property (
        $rose(sclk) |-> sclk [*4])
        else $error("serial clock high phase too short");
    chk_read_change: assert property (
        !sdio_dev_oe_n && $past(sdio_dev_oe_n) == 1'b0
        && $changed(sdio_dev_o) |-> !sclk)
        else $error("read bit changed while clock high");
    chk_four_wire: assert property (
        !sdo_oe_n && $past(sdo_oe_n) == 1'b0 && $changed(sdo) |-> !sclk)
        else $error("readback pin changed while clock high");
    chk_length_zero: assert property (
        sclk && !sclk_q && (rise_cnt == 6'h01 || rise_cnt == 6'h02)
        |-> sdio == 1'b0)
        else $error("length bit sent as one");
    chk_frame_len: assert property (
        $rose(cs_n) |-> rise_cnt == 6'h18 && $past(sclk, 2) == 1'b0)
        else $error("frame not closed after 24 bits");
endmodule

// ==== tb/serial_config_port_test.sv ====
// self-checking bench joining host and device ends of the link
`timescale 1ns/1ps
`include "scp_params.svh"
module serial_config_port_test;
    logic        clk_sys;
    logic        rst;
    logic        req;
    logic        req_read;
    logic        reset_req;
    logic        four_wire;
    logic [12:0] req_addr;
    logic [7:0]  req_data;
    logic [3:0]  cfg_idx;
    logic [7:0]  cfg_data;
    logic [7:0]  rd_data;
    logic        pin_reset;
    logic        wr_strobe;
    logic [7:0]  lfsr_q;
    logic [7:0]  mdl [0:15];
    logic [7:0]  strobes;
    int          error_cnt;
    int          n_tests;
    scp_link_if scp_link_if_i ();
    scp_host scp_host_i (.CLK_SYS(clk_sys), .RST(rst), .LINK(scp_link_if_i),
        .REQ(req), .REQ_READ(req_read), .REQ_ADDR(req_addr),
        .REQ_DATA(req_data), .RESET_REQ(reset_req), .BUSY(),
        .DONE(), .RD_DATA(rd_data));
    scp_device scp_device_i (.CLK_SYS(clk_sys), .RST(rst),
        .LINK(scp_link_if_i), .FOUR_WIRE(four_wire), .CFG_IDX(cfg_idx),
        .CFG_DATA(cfg_data), .PIN_RESET(pin_reset),
        .WRITE_STROBE(wr_strobe));
    scp_link_asserts scp_link_asserts_i (.CLK_SYS(clk_sys), .RST(rst),
        .sclk(scp_link_if_i.sclk), .cs_n(scp_link_if_i.cs_n),
        .sdio_host_o(scp_link_if_i.sdio_host_o),
        .sdio_host_oe_n(scp_link_if_i.sdio_host_oe_n),
        .sdio_dev_o(scp_link_if_i.sdio_dev_o),
        .sdio_dev_oe_n(scp_link_if_i.sdio_dev_oe_n),
        .sdo(scp_link_if_i.sdo), .sdo_oe_n(scp_link_if_i.sdo_oe_n),
        .rst_pin(scp_link_if_i.rst_pin), .sdio(scp_link_if_i.sdio));
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // one whole frame, then the register contents and strobe count
    task automatic op(input logic rd, input logic [12:0] a,
                      input logic [7:0] d);
        int n;
        n = 0;
        @(negedge clk_sys);
        strobes = 8'h00;
        req = 1'b1;
        req_read = rd;
        req_addr = a;
        req_data = d;
        @(negedge clk_sys);
        req = 1'b0;
        while (scp_host_i.DONE !== 1'b1 && n < 800) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 800)
            error_cnt++;
        repeat (12) @(negedge clk_sys);
        cfg_idx = a[3:0];
        #1;
        if (rd) begin
            chk(rd_data, mdl[a[3:0]]);
            chk(strobes, 8'h00);
        end else begin
            mdl[a[3:0]] = d;
            chk(strobes, 8'h01);
        end
        chk(cfg_data, mdl[a[3:0]]);
    endtask
    always @(posedge clk_sys) begin
        if (wr_strobe === 1'b1)
            strobes <= strobes + 8'h01;
    end
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial begin
        #3000000;
        error_cnt++;
        end_of_test();
    end
    initial begin
        int i;
        rst = 1'b1;
        req = 1'b0;
        req_read = 1'b0;
        reset_req = 1'b0;
        four_wire = 1'b0;
        req_addr = 13'h0000;
        req_data = 8'h00;
        cfg_idx = 4'h0;
        strobes = 8'h00;
        error_cnt = 0;
        n_tests = 0;
        lfsr_q = 8'h2E;
        for (i = 0; i < 16; i++)
            mdl[i] = 8'h00;
        repeat (16) @(negedge clk_sys);
        rst = 1'b0;
        op(1'b0, 13'h1FFF, 8'hFF);
        op(1'b0, 13'h0000, 8'h00);
        op(1'b0, 13'h0010, 8'h5A);
        op(1'b1, 13'h000F, 8'h00);
        $display("corner frames done");
        for (i = 0; i < 24; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            four_wire = lfsr_q[6];
            op(lfsr_q[7], {lfsr_q[1:0], 3'h0, lfsr_q}, lfsr_next(lfsr_q));
        end
        $display("random frames done");
        for (i = 0; i < 16; i++) begin
            four_wire = i[0];
            op(1'b1, 13'(i), 8'h00);
        end
        $display("readback sweep done");
        @(negedge clk_sys);
        reset_req = 1'b1;
        @(negedge clk_sys);
        reset_req = 1'b0;
        i = 0;
        while (pin_reset !== 1'b1 && i < 40) begin
            @(negedge clk_sys);
            i++;
        end
        chk({7'h00, pin_reset}, 8'h01);
        repeat (40) @(negedge clk_sys);
        for (i = 0; i < 16; i++) begin
            cfg_idx = 4'(i);
            mdl[i] = 8'h00;
            #1;
            chk(cfg_data, 8'h00);
        end
        op(1'b1, 13'h0003, 8'h00);
        $display("pin reset done");
        end_of_test();
    end
endmodule

// ==== verilog/scp_device.sv ====
// What this block does
// - capture data bit on each rising clock
// - chip select rise writes addressed register
// - header flag: 0 write, 1 read
// - host sends both length bits as zero
// - four-wire readback pin uses same timing
// - read data changes after falling clock edges
// - host releases chip select after transaction
// - reset pin held high at least 25 ns
`timescale 1ns/1ps
`include "scp_params.svh"
module scp_device
    import scp_pkg::*;
(
    input  wire logic                    CLK_SYS,
    input  wire logic                    RST,
    scp_link_if.dev                      LINK,
    input  wire logic                    FOUR_WIRE,
    input  wire logic [`SCP_IDX_W-1:0]   CFG_IDX,
    output      logic [`SCP_DATA_W-1:0]  CFG_DATA,
    output      logic                    PIN_RESET,
    output      logic                    WRITE_STROBE
);
    // three-stage samplers for link pins
    logic [2:0] s_clk, s_cs, s_dat, s_rp;
    logic [2:0] next_s_clk, next_s_cs, next_s_dat, next_s_rp;
    logic                     clk_q, cs_q, dat_q, rp_q;
    logic                     next_clk_q, next_cs_q, next_dat_q, next_rp_q;
    logic [`SCP_FRAME_W-1:0]  shreg, next_shreg;
    logic [`SCP_CNT_W-1:0]    cnt, next_cnt;
    logic [`SCP_DATA_W-1:0]   rd_sh, next_rd_sh;
    logic                     rd_bit, next_rd_bit;
    logic                     rd_act, next_rd_act;
    logic                     strobe, next_strobe;
    logic [`SCP_DATA_W-1:0]   regs [`SCP_NUM_REGS];
    logic [`SCP_DATA_W-1:0]   next_regs [`SCP_NUM_REGS];
    logic                     clk_rise, clk_fall, cs_rise, cs_fall;
    logic [`SCP_IDX_W-1:0]    hdr_idx;
    logic [`SCP_IDX_W-1:0]    sh_idx;

    assign next_s_clk = {s_clk[1:0], LINK.sclk};
    assign next_s_cs  = {s_cs[1:0],  LINK.cs_n};
    assign next_s_dat = {s_dat[1:0], LINK.sdio};
    assign next_s_rp  = {s_rp[1:0],  LINK.rst_pin};

    always_comb begin
        next_clk_q = (s_clk[1] == s_clk[2]) ? s_clk[2] : clk_q;
        next_cs_q  = (s_cs[1]  == s_cs[2])  ? s_cs[2]  : cs_q;
        next_dat_q = (s_dat[1] == s_dat[2]) ? s_dat[2] : dat_q;
        next_rp_q  = (s_rp[1]  == s_rp[2])  ? s_rp[2]  : rp_q;
    end

    assign clk_rise = next_clk_q && !clk_q;
    assign clk_fall = !next_clk_q && clk_q;
    assign cs_rise  = next_cs_q && !cs_q;
    assign cs_fall  = !next_cs_q && cs_q;
    // index from address low bits after header (addr in bits 20:8)
    assign hdr_idx = shreg[`SCP_IDX_W-1:0];
    assign sh_idx  = shreg[`SCP_DATA_W+`SCP_IDX_W-1:`SCP_DATA_W];

    always_comb begin
        next_shreg  = shreg;
        next_cnt    = cnt;
        next_rd_sh  = rd_sh;
        next_rd_bit = rd_bit;
        next_rd_act = rd_act;
        next_strobe = 1'b0;
        for (int i = 0; i < `SCP_NUM_REGS; i++) begin
            next_regs[i] = regs[i];
        end
        if (cs_fall) begin
            next_cnt    = '0;
            next_rd_act = 1'b0;
        end else if (!cs_q && clk_rise) begin
            next_shreg = {shreg[`SCP_FRAME_W-2:0], dat_q};
            if (cnt != `SCP_CNT_W'(`SCP_FRAME_W)) begin
                next_cnt = cnt + `SCP_CNT_W'(1);
            end
            // header plus address complete: load read data
            if (cnt == `SCP_CNT_W'(`SCP_FRAME_W - `SCP_DATA_W - 1) &&
                shreg[`SCP_FRAME_W-`SCP_DATA_W-2]) begin
                next_rd_act = 1'b1;
                next_rd_sh  = regs[{shreg[`SCP_IDX_W-2:0], dat_q}];
            end
        end else if (!cs_q && clk_fall && rd_act) begin
            next_rd_bit = rd_sh[`SCP_DATA_W-1];
            next_rd_sh  = {rd_sh[`SCP_DATA_W-2:0], 1'b0};
        end else if (cs_rise) begin
            next_rd_act = 1'b0;
            if (cnt == `SCP_CNT_W'(`SCP_FRAME_W) &&
                !shreg[`SCP_HDR_RW_BIT]) begin
                next_regs[sh_idx] = shreg[`SCP_DATA_W-1:0];
                next_strobe = 1'b1;
            end
        end
        if (cs_q) begin
            next_rd_act = 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            s_clk  <= 3'h0;
            s_cs   <= 3'h7;
            s_dat  <= 3'h0;
            s_rp   <= 3'h0;
            clk_q  <= 1'b0;
            cs_q   <= 1'b1;
            dat_q  <= 1'b0;
            rp_q   <= 1'b0;
            shreg  <= '0;
            cnt    <= '0;
            rd_sh  <= '0;
            rd_bit <= 1'b0;
            rd_act <= 1'b0;
            strobe <= 1'b0;
            for (int i = 0; i < `SCP_NUM_REGS; i++) begin
                regs[i] <= '0;
            end
        end else if (rp_q) begin
            s_clk  <= next_s_clk;
            s_cs   <= next_s_cs;
            s_dat  <= next_s_dat;
            s_rp   <= next_s_rp;
            clk_q  <= next_clk_q;
            cs_q   <= next_cs_q;
            dat_q  <= next_dat_q;
            rp_q   <= next_rp_q;
            shreg  <= '0;
            cnt    <= '0;
            rd_act <= 1'b0;
            strobe <= 1'b0;
            for (int i = 0; i < `SCP_NUM_REGS; i++) begin
                regs[i] <= '0;
            end
        end else begin
            s_clk  <= next_s_clk;
            s_cs   <= next_s_cs;
            s_dat  <= next_s_dat;
            s_rp   <= next_s_rp;
            clk_q  <= next_clk_q;
            cs_q   <= next_cs_q;
            dat_q  <= next_dat_q;
            rp_q   <= next_rp_q;
            shreg  <= next_shreg;
            cnt    <= next_cnt;
            rd_sh  <= next_rd_sh;
            rd_bit <= next_rd_bit;
            rd_act <= next_rd_act;
            strobe <= next_strobe;
            for (int i = 0; i < `SCP_NUM_REGS; i++) begin
                regs[i] <= next_regs[i];
            end
        end
    end

    // readback on sdio in three-wire mode, on sdo in four-wire mode
    assign LINK.sdio_dev_o    = rd_bit;
    assign LINK.sdio_dev_oe_n = !(rd_act && !FOUR_WIRE);
    assign LINK.sdo           = rd_bit;
    assign LINK.sdo_oe_n      = !(rd_act && FOUR_WIRE);
    assign CFG_DATA     = regs[CFG_IDX];
    assign PIN_RESET    = rp_q;
    assign WRITE_STROBE = strobe;
endmodule

// ==== verilog/scp_host.sv ====
// host controller end driving the serial configuration link
`timescale 1ns/1ps
`include "scp_params.svh"
module scp_host
    import scp_pkg::*;
(
    input  wire logic                    CLK_SYS,
    input  wire logic                    RST,
    scp_link_if.host                     LINK,
    input  wire logic                    REQ,
    input  wire logic                    REQ_READ,
    input  wire logic [`SCP_ADDR_W-3:0]  REQ_ADDR,
    input  wire logic [`SCP_DATA_W-1:0]  REQ_DATA,
    input  wire logic                    RESET_REQ,
    output      logic                    BUSY,
    output      logic                    DONE,
    output      logic [`SCP_DATA_W-1:0]  RD_DATA
);
    scp_host_state_t          state, next_state;
    logic [`SCP_FRAME_W-1:0]  sh, next_sh;
    logic [`SCP_DATA_W-1:0]   rd, next_rd;
    logic [`SCP_CNT_W-1:0]    cnt, next_cnt;
    logic [`SCP_DIV_W-1:0]    div, next_div;
    logic                     sclk, next_sclk;
    logic                     cs_n, next_cs_n;
    logic                     oe_n, next_oe_n;
    logic                     rdir, next_rdir;
    logic                     done, next_done;
    logic                     rpin, next_rpin;
    logic [2:0]               s_in, next_s_in;
    logic                     in_q, next_in_q;
    logic                     tick;

    assign tick = (div == `SCP_DIV_W'(`SCP_DIV_HALF - 1));
    // released lines idle high, so the driven one decides the bit
    assign next_s_in = {s_in[1:0], LINK.sdio & LINK.sdo_line};
    assign next_in_q = (s_in[1] == s_in[2]) ? s_in[2] : in_q;

    always_comb begin
        next_state = state;
        next_sh    = sh;
        next_rd    = rd;
        next_cnt   = cnt;
        next_div   = tick ? '0 : div + `SCP_DIV_W'(1);
        next_sclk  = sclk;
        next_cs_n  = cs_n;
        next_oe_n  = oe_n;
        next_rdir  = rdir;
        next_done  = 1'b0;
        next_rpin  = 1'b0;
        unique case (state)
            SCP_IDLE: begin
                next_div = '0;
                if (RESET_REQ) begin
                    next_state = SCP_RST;
                    next_cnt   = '0;
                    next_rpin  = 1'b1;
                end else if (REQ) begin
                    // length bits sent as zero
                    next_sh = {REQ_READ, 2'b00, REQ_ADDR, REQ_DATA};
                    next_rdir  = REQ_READ;
                    next_cs_n  = 1'b0;
                    next_oe_n  = 1'b0;
                    next_cnt   = '0;
                    next_state = SCP_SHIFT;
                end
            end
            SCP_SHIFT: begin
                if (tick) begin
                    next_sclk = !sclk;
                    if (!sclk) begin
                        if (rdir && cnt >= `SCP_CNT_W'(`SCP_FRAME_W -
                                                       `SCP_DATA_W)) begin
                            next_rd = {rd[`SCP_DATA_W-2:0], next_in_q};
                        end
                        // last address bit is held by the device's
                        // sampler delay; release before it drives
                        if (rdir && cnt == `SCP_CNT_W'(
                                `SCP_FRAME_W - `SCP_DATA_W - 1)) begin
                            next_oe_n = 1'b1;
                        end
                        next_cnt = cnt + `SCP_CNT_W'(1);
                    end else begin
                        // data changes on falling edge, held for rise
                        next_sh = {sh[`SCP_FRAME_W-2:0], 1'b0};
                        if (cnt == `SCP_CNT_W'(`SCP_FRAME_W)) begin
                            next_sclk  = 1'b0;
                            next_state = SCP_DONE;
                        end
                    end
                end
            end
            SCP_DONE: begin
                if (tick) begin
                    next_cs_n  = 1'b1;
                    next_oe_n  = 1'b1;
                    next_done  = 1'b1;
                    next_state = SCP_IDLE;
                end
            end
            SCP_RST: begin
                next_rpin = 1'b1;
                next_cnt  = cnt + `SCP_CNT_W'(1);
                if (cnt == `SCP_CNT_W'(`SCP_RST_CYC)) begin
                    next_rpin  = 1'b0;
                    next_state = SCP_IDLE;
                end
            end
            default: next_state = SCP_IDLE;
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            state <= SCP_IDLE;
            sh    <= '0;
            rd    <= '0;
            cnt   <= '0;
            div   <= '0;
            sclk  <= 1'b0;
            cs_n  <= 1'b1;
            oe_n  <= 1'b1;
            rdir  <= 1'b0;
            done  <= 1'b0;
            rpin  <= 1'b0;
            s_in  <= 3'h0;
            in_q  <= 1'b0;
        end else begin
            state <= next_state;
            sh    <= next_sh;
            rd    <= next_rd;
            cnt   <= next_cnt;
            div   <= next_div;
            sclk  <= next_sclk;
            cs_n  <= next_cs_n;
            oe_n  <= next_oe_n;
            rdir  <= next_rdir;
            done  <= next_done;
            rpin  <= next_rpin;
            s_in  <= next_s_in;
            in_q  <= next_in_q;
        end
    end

    assign LINK.sclk           = sclk;
    assign LINK.cs_n           = cs_n;
    assign LINK.sdio_host_o    = sh[`SCP_FRAME_W-1];
    assign LINK.sdio_host_oe_n = oe_n;
    assign LINK.rst_pin        = rpin;
    assign BUSY    = (state != SCP_IDLE);
    assign DONE    = done;
    assign RD_DATA = rd;
endmodule

// ==== verilog/scp_link_if.sv ====
// link between host controller and configuration port device
`timescale 1ns/1ps
interface scp_link_if;
    logic sclk;
    logic cs_n;
    logic sdio_host_o;
    logic sdio_host_oe_n;
    logic sdio_dev_o;
    logic sdio_dev_oe_n;
    logic sdo;
    logic sdo_oe_n;
    logic rst_pin;
    logic sdio;
    logic sdo_line;
    assign sdio = !sdio_host_oe_n ? sdio_host_o :
                  (!sdio_dev_oe_n ? sdio_dev_o : 1'b1);
    // readback pin as the host sees it: pulled up while released
    assign sdo_line = !sdo_oe_n ? sdo : 1'b1;
    modport host (output sclk, output cs_n, output sdio_host_o,
                  output sdio_host_oe_n, output rst_pin,
                  input sdio, input sdo_line);
    modport dev  (input sclk, input cs_n, input sdio, input rst_pin,
                  output sdio_dev_o, output sdio_dev_oe_n,
                  output sdo, output sdo_oe_n);
endinterface

// ==== verilog/scp_params.svh ====
// timing and frame constants for the serial configuration port
`ifndef SCP_PARAMS_SVH
`define SCP_PARAMS_SVH
`define SCP_ADDR_W        15
`define SCP_DATA_W        8
`define SCP_FRAME_W       24
`define SCP_CNT_W         5
`define SCP_HDR_RW_BIT    23
`define SCP_HDR_LEN_HI    22
`define SCP_HDR_LEN_LO    21
`define SCP_NUM_REGS      16
`define SCP_IDX_W         4
`define SCP_CLK_NS        50
`define SCP_RST_MIN_NS    25
`define SCP_RST_CYC ((`SCP_RST_MIN_NS + `SCP_CLK_NS - 1) / `SCP_CLK_NS)
`define SCP_DIV_HALF      8
`define SCP_DIV_W         3
`endif

// ==== verilog/scp_pkg.sv ====
// host controller state type for the serial configuration port
package scp_pkg;
    typedef enum logic [3:0] {
        SCP_IDLE  = 4'h1,
        SCP_SHIFT = 4'h2,
        SCP_DONE  = 4'h4,
        SCP_RST   = 4'h8
    } scp_host_state_t;
endpackage
